// *** hw/pemux_pkg.sv ***
// Package with register map, field positions and reset values of the low port mux.
package pemux_pkg;
    localparam int PEMUX_PINS = 5;
    localparam logic [7:0] PEMUX_OFF_LATCH = 8'h00;
    localparam logic [7:0] PEMUX_OFF_DIR = 8'h04;
    localparam logic [7:0] PEMUX_OFF_READ = 8'h08;
    localparam logic [7:0] PEMUX_OFF_CFG = 8'h0C;
    localparam int PEMUX_CFG_EXT_DIS = 0;
    localparam int PEMUX_CFG_PAR_SEL = 1;
    localparam int PEMUX_CFG_REMAP = 2;
    localparam int PEMUX_CFG_REF_EN = 3;
    localparam int PEMUX_CFG_TRI_LSB = 8;
    localparam int PEMUX_CFG_DIV_LSB = 16;
    localparam int PEMUX_DIV_W = 8;
    localparam logic [4:0] PEMUX_LATCH_RST = 5'h00;
    localparam logic [4:0] PEMUX_DIR_RST = 5'h1F;
    localparam logic [4:0] PEMUX_OE_N_RST = 5'h1F;
    localparam logic [31:0] PEMUX_CFG_RST = 32'h00000007;
    localparam logic [31:0] PEMUX_CFG_MASK = 32'h00FF1F0F;
    localparam logic [PEMUX_DIV_W-1:0] PEMUX_DIV_RST = 8'h00;
endpackage

// *** hw/pemux_refclk_div.sv ***
// Reference clock divider that derives the reference output from the system clock.
`timescale 1ns/1ps
module pemux_refclk_div #(
    parameter int DIV_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    input wire logic [DIV_W-1:0] divisor,
    output logic clk_out
);
    import pemux_pkg::*;

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic clk_reg;
    logic clk_next;

    // Toggle the output each time the count reaches the divisor; a divisor of zero halves hclk.
    always_comb begin
        cnt_next = cnt_reg;
        clk_next = clk_reg;
        if (!enable) begin
            cnt_next = PEMUX_DIV_RST;
            clk_next = 1'b0;
        end else if (cnt_reg >= divisor) begin
            cnt_next = PEMUX_DIV_RST;
            clk_next = ~clk_reg;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
    end

    // Divider state registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= PEMUX_DIV_RST;
            clk_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            clk_reg <= clk_next;
        end
    end

    assign clk_out = clk_reg;
endmodule

// *** hw/pemux_top.sv ***
// Pin function multiplexer for the five low pins of the port, with an AHB-Lite register slave.
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module pemux_top #(
    parameter bit EXT_BUS_PRESENT = 1'b1,
    parameter int PINS = 5
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n,
    input wire logic [PINS-1:0] ext_bus_addr_data_out,
    input wire logic ext_bus_drive,
    output logic [PINS-1:0] ext_bus_data_in,
    input wire logic par_port_master,
    input wire logic [PINS-1:0] par_port_func_sel,
    input wire logic [PINS-1:0] par_port_out,
    output logic [1:0] par_port_strobe_in,
    input wire logic [PINS-1:0] pwm_chan_out,
    input wire logic [PINS-1:0] pwm_chan_en,
    input wire logic pwm_shutdown
);
    import pemux_pkg::*;

    logic [PINS-1:0] latch_reg, latch_next;
    logic [PINS-1:0] port_e_direction, dir_next;
    logic [31:0] cfg_reg, cfg_next;
    logic [PINS-1:0] port_e_pin_read, pin_read_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic addr_phase;
    logic [PINS-1:0] out_reg, out_next;
    logic [PINS-1:0] oe_n_reg, oe_n_next;
    logic [PINS-1:0] ext_in_reg, ext_in_next;
    logic [1:0] strobe_in_reg, strobe_in_next;
    logic hready_reg, hresp_reg;
    logic ext_bus_disable, par_port_pin_select_cfg, pwm_remap_cfg, ref_en;
    logic [PINS-1:0] pwm_tri_cfg;
    logic ext_own;
    logic [PINS-1:0] pwm_own, par_own;
    logic ref_own;
    logic reference_clock_out;

    assign ext_bus_disable = cfg_reg[PEMUX_CFG_EXT_DIS];
    assign par_port_pin_select_cfg = cfg_reg[PEMUX_CFG_PAR_SEL];
    assign pwm_remap_cfg = cfg_reg[PEMUX_CFG_REMAP];
    assign ref_en = cfg_reg[PEMUX_CFG_REF_EN];
    assign pwm_tri_cfg = cfg_reg[PEMUX_CFG_TRI_LSB +: PINS];

    // Reference clock generator derived from hclk.
    pemux_refclk_div #(
        .DIV_W(PEMUX_DIV_W)
    ) u_refclk (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(ref_en),
        .divisor(cfg_reg[PEMUX_CFG_DIV_LSB +: PEMUX_DIV_W]),
        .clk_out(reference_clock_out)
    );

    assign ext_own = EXT_BUS_PRESENT && !ext_bus_disable;
    assign ref_own = ref_en;

    // Per-pin ownership and next output, resolved in priority order.
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        logic routed;
        if (i >= 3) begin : g_remap
            assign routed = EXT_BUS_PRESENT ? pwm_remap_cfg : 1'b1;
        end else begin : g_fixed
            assign routed = 1'b1;
        end
        assign pwm_own[i] = pwm_chan_en[i] && !port_e_direction[i] && routed;
        assign par_own[i] = par_port_pin_select_cfg && par_port_func_sel[i];

        always_comb begin
            if (ext_own) begin
                out_next[i] = ext_bus_addr_data_out[i];
                oe_n_next[i] = !ext_bus_drive;
            end else if (pwm_own[i]) begin
                out_next[i] = pwm_chan_out[i];
                oe_n_next[i] = pwm_shutdown && pwm_tri_cfg[i];
            end else if (par_own[i]) begin
                out_next[i] = par_port_out[i];
                oe_n_next[i] = (i < 2) ? !par_port_master : 1'b0;
            end else if ((i == 3) && ref_own) begin
                out_next[i] = reference_clock_out;
                oe_n_next[i] = 1'b0;
            end else begin
                out_next[i] = latch_reg[i];
                oe_n_next[i] = port_e_direction[i];
            end
        end
    end

    // Input paths back to the bus and the parallel port, plus the port read value.
    always_comb begin
        pin_read_next = pin_in;
        ext_in_next = ext_own ? pin_in : '0;
        strobe_in_next = 2'b00;
        for (int k = 0; k < 2; k++) begin
            if (!ext_own && !pwm_own[k] && par_own[k] && !par_port_master) begin
                strobe_in_next[k] = pin_in[k];
            end
        end
    end

    // AHB-Lite address phase capture and register access.
    assign addr_phase = hsel && htrans[1] && hready;
    always_comb begin
        wr_pend_next = addr_phase && hwrite;
        addr_next = addr_phase ? haddr[7:0] : addr_reg;
        hrdata_next = hrdata_reg;
        latch_next = latch_reg;
        dir_next = port_e_direction;
        cfg_next = cfg_reg;
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                PEMUX_OFF_LATCH: hrdata_next = 32'(latch_reg);
                PEMUX_OFF_DIR: hrdata_next = 32'(port_e_direction);
                PEMUX_OFF_READ: hrdata_next = 32'(port_e_pin_read);
                PEMUX_OFF_CFG: hrdata_next = cfg_reg;
                default: hrdata_next = 32'h00000000;
            endcase
        end
        if (wr_pend_reg) begin
            case (addr_reg)
                PEMUX_OFF_LATCH: latch_next = hwdata[PINS-1:0];
                PEMUX_OFF_DIR: dir_next = hwdata[PINS-1:0];
                PEMUX_OFF_CFG: cfg_next = hwdata & PEMUX_CFG_MASK;
                default: cfg_next = cfg_reg;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_reg <= PEMUX_LATCH_RST;
            port_e_direction <= PEMUX_DIR_RST;
            cfg_reg <= PEMUX_CFG_RST;
            port_e_pin_read <= '0;
            hrdata_reg <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            out_reg <= '0;
            oe_n_reg <= PEMUX_OE_N_RST;
            ext_in_reg <= '0;
            strobe_in_reg <= 2'b00;
            hready_reg <= 1'b0;
            hresp_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            port_e_direction <= dir_next;
            cfg_reg <= cfg_next;
            port_e_pin_read <= pin_read_next;
            hrdata_reg <= hrdata_next;
            wr_pend_reg <= wr_pend_next;
            addr_reg <= addr_next;
            out_reg <= out_next;
            oe_n_reg <= oe_n_next;
            ext_in_reg <= ext_in_next;
            strobe_in_reg <= strobe_in_next;
            hready_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    // Registered outputs.
    assign hreadyout = hready_reg;
    assign hresp = hresp_reg;
    assign hrdata = hrdata_reg;
    assign pin_out = out_reg;
    assign pin_oe_n = oe_n_reg;
    assign ext_bus_data_in = ext_in_reg;
    assign par_port_strobe_in = strobe_in_reg;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Checks of the pin resolution and register effects.
    sequence s_cfg_write;
        addr_phase && hwrite && (haddr[7:0] == PEMUX_OFF_CFG) ##1 1'b1;
    endsequence

    a_bus_override: assert property (ext_own
        |=> (pin_out == $past(ext_bus_addr_data_out))
        && (pin_oe_n == {PINS{!$past(ext_bus_drive)}}))
        else $error("bus does not own pins");
    a_bus_data_in: assert property (ext_own |=> ext_bus_data_in == $past(pin_in))
        else $error("bus data input wrong");
    a_small_no_bus: assert property (!EXT_BUS_PRESENT |-> ext_bus_data_in == '0)
        else $error("bus path in small package");
    a_pwm_priority: assert property (!ext_own && pwm_chan_en[0] && !port_e_direction[0]
        |=> pin_out[0] == $past(pwm_chan_out[0]))
        else $error("pwm lost priority");
    a_pwm_shutdown: assert property (!ext_own && pwm_own[0] && pwm_shutdown
        && pwm_tri_cfg[0] |=> pin_oe_n[0])
        else $error("pwm not floated in shutdown");
    a_read_strobe: assert property (!ext_own && !pwm_own[0] && par_own[0]
        |=> pin_oe_n[0] == !$past(par_port_master))
        else $error("read strobe direction wrong");
    a_write_strobe_in: assert property (!ext_own && !pwm_own[1] && par_own[1]
        && !par_port_master |=> par_port_strobe_in[1] == $past(pin_in[1]) && pin_oe_n[1])
        else $error("write strobe input wrong");
    a_addr_pin: assert property (!ext_own && !pwm_own[3] && par_own[3]
        |=> !pin_oe_n[3] && pin_out[3] == $past(par_port_out[3]))
        else $error("address pin wrong");
    a_port_mode: assert property (!ext_own && !pwm_own[4] && !par_own[4]
        |=> pin_oe_n[4] == $past(port_e_direction[4])
        && (pin_out[4] == $past(latch_reg[4])))
        else $error("port mode wrong");
    a_cfg_disable: assert property (s_cfg_write |=> ext_bus_disable == $past(hwdata[0]))
        else $error("bus disable not stored");
    a_refclk_pin: assert property (!ext_own && !pwm_own[3] && !par_own[3] && ref_own
        |=> !pin_oe_n[3] && pin_out[3] == $past(reference_clock_out))
        else $error("reference clock missing");
    a_reset_input: assert property (@(posedge hclk) $rose(hresetn) |-> pin_oe_n == '1)
        else $error("pins not inputs after reset");

    // Register writes that steer the pins land one edge after their data phase.
    sequence s_dir_write;
        addr_phase && hwrite && (haddr[7:0] == PEMUX_OFF_DIR) ##1 1'b1;
    endsequence
    sequence s_latch_write;
        addr_phase && hwrite && (haddr[7:0] == PEMUX_OFF_LATCH) ##1 1'b1;
    endsequence
    a_dir_write: assert property (s_dir_write
        |=> port_e_direction == $past(hwdata[PINS-1:0]))
        else $error("direction write lost");
    a_latch_write: assert property (s_latch_write
        |=> latch_reg == $past(hwdata[PINS-1:0]))
        else $error("latch write lost");
    // Parallel functions drive their pins whatever the direction bits say; pins 0 and 1 are driven only as master.
    a_strobe_out: assert property (!ext_own && !pwm_own[0] && par_own[0]
        && par_port_master |=> !pin_oe_n[0] && pin_out[0] == $past(par_port_out[0]))
        else $error("read strobe not driven as master");
    a_byte_enable: assert property (!ext_own && !pwm_own[2] && par_own[2]
        |=> !pin_oe_n[2] && pin_out[2] == $past(par_port_out[2]))
        else $error("byte enable pin wrong");
    a_addr12_pin: assert property (!ext_own && !pwm_own[4] && par_own[4]
        |=> !pin_oe_n[4] && pin_out[4] == $past(par_port_out[4]))
        else $error("upper address pin wrong");
    a_dir_override: assert property (!ext_own && !pwm_own[4] && par_own[4]
        && port_e_direction[4] |=> !pin_oe_n[4])
        else $error("direction bit not overridden");
    a_par_select: assert property (!ext_own && !par_port_pin_select_cfg && !pwm_own[2]
        |=> pin_oe_n[2] == $past(port_e_direction[2])
        && (pin_out[2] == $past(latch_reg[2])))
        else $error("parallel function without select");
    // PWM channel routing, with and without the remap bit.
    a_second_pwm_c: assert property (!ext_own && pwm_chan_en[1] && !port_e_direction[1]
        && !pwm_shutdown |=> !pin_oe_n[1] && pin_out[1] == $past(pwm_chan_out[1]))
        else $error("second pwm channel c lost");
    a_second_pwm_b: assert property (!ext_own && pwm_chan_en[2] && !port_e_direction[2]
        && !pwm_shutdown |=> !pin_oe_n[2] && pin_out[2] == $past(pwm_chan_out[2]))
        else $error("second pwm channel b lost");
    a_pwm_remap: assert property (EXT_BUS_PRESENT && !ext_own && !pwm_remap_cfg
        && pwm_chan_en[4] && !port_e_direction[4] && par_own[4]
        |=> pin_out[4] == $past(par_port_out[4]))
        else $error("pwm not moved off by remap");
    a_small_pwm: assert property (!EXT_BUS_PRESENT && pwm_chan_en[3]
        && !port_e_direction[3] |=> pin_out[3] == $past(pwm_chan_out[3]))
        else $error("small package pwm not on pin");
endmodule

// *** verif/pemux_pin_partner.sv ***
// Far-side model of the loads and peripheral drivers on the five low port pins.
`timescale 1ns/1ps
module pemux_pin_partner (
    input wire logic hclk,
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe_n,
    input wire logic [4:0] far_en,
    input wire logic [4:0] far_val,
    output logic [4:0] pin_in
);
    logic [4:0] wobble = 5'h15;
    // A floating pin shows a pattern that changes every cycle, never a settled level.
    always @(posedge hclk) begin
        wobble <= ~wobble;
    end
    // slave strobe drive
    // Released pins that the far side owns carry its value; a driven pin shows the device.
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (far_en[i] ? far_val[i] : wobble[i]);
        end
    end
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the low port pin mux and its register slave.
`timescale 1ns/1ps
module tb;
    import pemux_pkg::*;
    logic hclk, hready, hreadyout, hresp;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext_bus_drive = 1'b0;
    logic par_port_master = 1'b0, pwm_shutdown = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, par_port_strobe_in;
    logic [2:0] hsize = 3'h2;
    logic [4:0] ext_bus_addr_data_out = 5'h00, par_port_func_sel = 5'h00, par_port_out = 5'h00;
    logic [4:0] pwm_chan_out = 5'h00, pwm_chan_en = 5'h00, far_en = 5'h00, far_val = 5'h00;
    logic [4:0] pin_in, pin_out, pin_oe_n, ext_bus_data_in, s_out, s_oe_n, s_edi, ref_a;
    int error_cnt = 0, compares = 0;
    assign hready = hreadyout;
    // Full package variant under test.
    pemux_top dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_bus_addr_data_out(ext_bus_addr_data_out),
        .ext_bus_drive(ext_bus_drive), .ext_bus_data_in(ext_bus_data_in),
        .par_port_master(par_port_master), .par_port_func_sel(par_port_func_sel),
        .par_port_out(par_port_out), .par_port_strobe_in(par_port_strobe_in),
        .pwm_chan_out(pwm_chan_out), .pwm_chan_en(pwm_chan_en), .pwm_shutdown(pwm_shutdown)
    );
    // Small package variant, sharing the bus and the pin levels.
    pemux_top #(.EXT_BUS_PRESENT(1'b0)) dut_small (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(), .hresp(), .hrdata(), .pin_in(pin_in),
        .pin_out(s_out), .pin_oe_n(s_oe_n), .ext_bus_addr_data_out(ext_bus_addr_data_out),
        .ext_bus_drive(ext_bus_drive), .ext_bus_data_in(s_edi),
        .par_port_master(par_port_master), .par_port_func_sel(par_port_func_sel),
        .par_port_out(par_port_out), .par_port_strobe_in(),
        .pwm_chan_out(pwm_chan_out), .pwm_chan_en(pwm_chan_en), .pwm_shutdown(pwm_shutdown)
    );
    pemux_pin_partner far (
        .hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .far_en(far_en),
        .far_val(far_val), .pin_in(pin_in)
    );
    // Free-running system clock.
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // One single AHB-Lite transfer; read data lands in rd.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
        chk_reg({27'h0, got}, {27'h0, exp});
    endtask
    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask
    task automatic conclude();
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog that cuts a hung run short.
    initial begin
        repeat (3000) @(posedge hclk);
        error_cnt++;
        conclude();
    end
    // Main sequence of scenarios.
    initial begin
        repeat (3) @(posedge hclk);
        chk_pin(pin_oe_n, 5'h1F);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(0, PEMUX_OFF_CFG, 32'h0);
        chk_reg(rd, 32'h00000007);
        chk_reg({31'h0, hresp}, 32'h00000000);
        ahb(0, PEMUX_OFF_DIR, 32'h0);
        chk_reg(rd, 32'h0000001F);
        ahb(1, 8'h10, 32'hFFFFFFFF);
        ahb(0, 8'h10, 32'h0);
        chk_reg(rd, 32'h00000000);
        // Port mode with mixed directions and far-side levels on the inputs.
        ahb(1, PEMUX_OFF_CFG, 32'h00000005);
        ahb(1, PEMUX_OFF_DIR, 32'h0000000A);
        ahb(1, PEMUX_OFF_LATCH, 32'h00000015);
        far_en <= 5'h1F;
        far_val <= 5'h08;
        settle();
        chk_pin(pin_oe_n, 5'h0A);
        chk_pin(pin_out | 5'h0A, 5'h1F);
        chk_pin(s_oe_n, 5'h0A);
        ahb(0, PEMUX_OFF_READ, 32'h0);
        chk_reg(rd, 32'h0000001D);
        // PWM against parallel functions, direction, remap and shutdown.
        ahb(1, PEMUX_OFF_CFG, 32'h00000007);
        ahb(1, PEMUX_OFF_DIR, 32'h00000000);
        pwm_chan_en <= 5'h1F;
        pwm_chan_out <= 5'h0A;
        par_port_func_sel <= 5'h1F;
        par_port_master <= 1'b1;
        par_port_out <= 5'h15;
        settle();
        chk_pin(pin_out, 5'h0A);
        chk_pin(pin_oe_n, 5'h00);
        ahb(1, PEMUX_OFF_CFG, 32'h00000003);
        settle();
        chk_pin(pin_out, 5'h12);
        chk_pin(s_out, 5'h0A);
        ahb(1, PEMUX_OFF_CFG, 32'h00000507);
        pwm_shutdown <= 1'b1;
        settle();
        chk_pin(pin_oe_n, 5'h05);
        ahb(1, PEMUX_OFF_DIR, 32'h0000001F);
        settle();
        chk_pin(pin_out, 5'h15);
        chk_pin(pin_oe_n, 5'h00);
        // Parallel port as slave, then with the pin select cleared.
        pwm_shutdown <= 1'b0;
        pwm_chan_en <= 5'h00;
        par_port_master <= 1'b0;
        far_val <= 5'h02;
        settle();
        chk_pin(pin_oe_n, 5'h03);
        chk_pin({3'h0, par_port_strobe_in}, 5'h02);
        ahb(1, PEMUX_OFF_CFG, 32'h00000005);
        settle();
        chk_pin(pin_oe_n, 5'h1F);
        // Reference clock on pin 3, toggling every cycle.
        par_port_func_sel <= 5'h00;
        ahb(1, PEMUX_OFF_CFG, 32'h0000000D);
        settle();
        chk_pin(pin_oe_n, 5'h17);
        ref_a = pin_out;
        @(posedge hclk);
        chk_pin(pin_out & 5'h08, ~ref_a & 5'h08);
        // A divisor of two holds each level of the reference clock for three cycles.
        ahb(1, PEMUX_OFF_CFG, 32'h0002000D);
        settle();
        ref_a = pin_out;
        while (pin_out[3] === ref_a[3]) begin
            @(posedge hclk);
        end
        ref_a = pin_out;
        repeat (2) @(posedge hclk);
        chk_pin(pin_out & 5'h08, ref_a & 5'h08);
        @(posedge hclk);
        chk_pin(pin_out & 5'h08, ~ref_a & 5'h08);
        // External bus owns the pins over everything else.
        pwm_chan_en <= 5'h1F;
        par_port_func_sel <= 5'h1F;
        par_port_master <= 1'b1;
        ext_bus_drive <= 1'b1;
        ext_bus_addr_data_out <= 5'h13;
        ahb(1, PEMUX_OFF_CFG, 32'h0000000E);
        settle();
        chk_pin(pin_out, 5'h13);
        chk_pin(pin_oe_n, 5'h00);
        chk_pin(s_out, 5'h15);
        ext_bus_drive <= 1'b0;
        far_val <= 5'h0B;
        settle();
        chk_pin(pin_oe_n, 5'h1F);
        chk_pin(ext_bus_data_in, 5'h0B);
        chk_pin(s_edi, 5'h00);
        // A second reset in mid-run returns every pin to input.
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        chk_pin(pin_oe_n, 5'h1F);
        conclude();
    end
endmodule
